/* rmp_map.svh */
// Constants for the ROM and dual port bus block
`ifndef RMP_MAP_SVH
`define RMP_MAP_SVH
`define RMP_ROM_DEPTH 2048
`define RMP_ROM_AW 11
`define RMP_DW 8
`define RMP_SEL_PORT_A 2'h0
`define RMP_SEL_PORT_B 2'h1
`define RMP_SEL_DIR_A 2'h2
`define RMP_SEL_DIR_B 2'h3
`define RMP_DIR_RESET 8'h00
`define RMP_BYTE_ZERO 8'h00
`endif

/* rmp_pkg.sv */
// Types shared by the ROM and port block
package rmp_pkg;
    typedef logic [7:0] rmp_byte_t;
    typedef enum logic [2:0] {
        RMP_WAIT_IDLE = 3'h1,
        RMP_WAIT_LOW = 3'h2,
        RMP_WAIT_HOLD = 3'h4
    } rmp_wait_t;
endpackage

/* rmp_rom.sv */
// Mask ROM image with registered read data
`timescale 1ns/100ps
`include "rmp_map.svh"
module rmp_rom (
    input wire logic sys_clk_i,
    input wire logic [`RMP_ROM_AW-1:0] addr_i,
    output logic [`RMP_DW-1:0] data_o
);
    logic [`RMP_DW-1:0] mem [`RMP_ROM_DEPTH];
    logic [`RMP_DW-1:0] data_reg;
    // Fixed image, no write port exists
    initial begin
        for (int i = 0; i < `RMP_ROM_DEPTH; i++) begin
            mem[i] = i[7:0] ^ i[10:3];
        end
    end
    // Registered read
    always_ff @(posedge sys_clk_i) begin
        data_reg <= mem[addr_i];
    end
    assign data_o = data_reg;
endmodule

/* rmp_port.sv */
// Bus side of the ROM plus dual I/O port device
`timescale 1ns/100ps
`include "rmp_map.svh"
// What this block does
// - Latch address, selects, io select at strobe fall
// - Respond only if both selects latched active
// - Bus and wait float when a select inactive
// - ROM is 2048 bytes, eleven-bit address
// - Upper address bits ignored for port cycles
// - Read source is port or ROM by io select
// - Drive bus on read, float both strobes high
// - Port write strobe writes byte to selected target
// - Wait low during strobe, released next clock edge
// - Port A written at address bits 00
// - Port A read at address bits 00
// - Port B same but address bits 01
// - Reset clears both direction registers
// - Port read strobe reads port like io read
// - Each pin direction from its own bit
// - Zero input, one drives output latch
// - Address bit one selects direction registers
// - Direction registers cannot be read back
// - Pin data change only after write strobe rises; direction writes reach the pin enables during it
module rmp_port
    import rmp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic addr_latch_i,
    input wire logic chip_sel_low_active_i,
    input wire logic chip_sel_high_active_i,
    input wire logic io_mem_sel_i,
    input wire logic read_strobe_n_i,
    input wire logic port_read_strobe_n_i,
    input wire logic port_write_strobe_n_i,
    input wire logic [2:0] upper_rom_addr_i,
    input wire logic [7:0] muxed_addr_data_i,
    output logic [7:0] muxed_addr_data_o,
    output logic muxed_addr_data_oe_o,
    output logic wait_o,
    output logic wait_oe_o,
    input wire logic [7:0] first_port_pins_i,
    output logic [7:0] first_port_pins_o,
    output logic [7:0] first_port_pins_oe_o,
    input wire logic [7:0] second_port_pins_i,
    output logic [7:0] second_port_pins_o,
    output logic [7:0] second_port_pins_oe_o
);
    // Two-stage synchronisers for every pin input
    // Bus pins share one delay so address, strobes and data stay aligned
    logic [17:0] s1_reg, s2_reg;
    always_ff @(posedge sys_clk_i) begin
        s1_reg <= {addr_latch_i, chip_sel_low_active_i, chip_sel_high_active_i, io_mem_sel_i,
            read_strobe_n_i, port_read_strobe_n_i, port_write_strobe_n_i,
            upper_rom_addr_i, muxed_addr_data_i};
        s2_reg <= s1_reg;
    end
    logic [7:0] pa_sync_reg, pa_mid_reg, pb_sync_reg, pb_mid_reg;
    always_ff @(posedge sys_clk_i) begin
        pa_mid_reg <= first_port_pins_i;
        pa_sync_reg <= pa_mid_reg;
        pb_mid_reg <= second_port_pins_i;
        pb_sync_reg <= pb_mid_reg;
    end
    logic ale, ce_n, ce, iom, rd_n, prd_n, pwr_n;
    logic [2:0] up;
    logic [7:0] ad;
    assign {ale, ce_n, ce, iom, rd_n, prd_n, pwr_n, up, ad} = s2_reg;

    // Address latch: transparent while strobe high, holds after fall
    logic [7:0] lo_reg, lo_next;
    logic [2:0] up_reg, up_next;
    logic iom_reg, iom_next, sel_ok_reg, sel_ok_next;
    always_comb begin
        lo_next = lo_reg;
        up_next = up_reg;
        iom_next = iom_reg;
        sel_ok_next = sel_ok_reg;
        if (ale) begin
            lo_next = ad;
            up_next = up;
            iom_next = iom;
            sel_ok_next = !ce_n && ce;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            lo_reg <= `RMP_BYTE_ZERO;
            up_reg <= 3'h0;
            iom_reg <= 1'b0;
            sel_ok_reg <= 1'b0;
        end else begin
            lo_reg <= lo_next;
            up_reg <= up_next;
            iom_reg <= iom_next;
            sel_ok_reg <= sel_ok_next;
        end
    end

    // Decode of the latched low bits; used for reads and writes
    function automatic logic sel_hit(input logic [7:0] a, input logic [1:0] code);
        sel_hit = (a[1:0] == code);
    endfunction

    // Port read request, either the dedicated strobe or io read
    logic port_rd, rom_rd, bus_drive;
    assign port_rd = sel_ok_reg && (!prd_n || (iom_reg && !rd_n));
    assign rom_rd = sel_ok_reg && !iom_reg && !rd_n;
    assign bus_drive = port_rd || rom_rd;

    // ROM lookup on latched eleven-bit address
    logic [7:0] rom_data;
    rmp_rom rmp_rom_inst (
        .sys_clk_i(sys_clk_i),
        .addr_i({up_reg, lo_reg}),
        .data_o(rom_data)
    );

    // Output data register; direction registers have no read path
    logic [7:0] dout_reg, dout_next;
    always_comb begin
        dout_next = rom_data;
        if (iom_reg || !prd_n) begin
            if (sel_hit(lo_reg, `RMP_SEL_PORT_B)) begin
                dout_next = pb_sync_reg;
            end else if (sel_hit(lo_reg, `RMP_SEL_PORT_A)) begin
                dout_next = pa_sync_reg;
            end else begin
                dout_next = `RMP_BYTE_ZERO;
            end
        end
    end

    // Port and direction latches, pin data updated after write strobe rises, pin enables during it
    logic [7:0] la_reg, la_next, lb_reg, lb_next, da_reg, da_next, db_reg, db_next;
    logic [7:0] oa_reg, oa_next, ob_reg, ob_next;
    logic pwr_d_reg;
    logic wr;
    assign wr = sel_ok_reg && !pwr_n;
    always_comb begin
        la_next = la_reg;
        lb_next = lb_reg;
        da_next = da_reg;
        db_next = db_reg;
        oa_next = oa_reg;
        ob_next = ob_reg;
        if (wr) begin
            if (sel_hit(lo_reg, `RMP_SEL_PORT_A)) la_next = ad;
            if (sel_hit(lo_reg, `RMP_SEL_PORT_B)) lb_next = ad;
            if (sel_hit(lo_reg, `RMP_SEL_DIR_A)) da_next = ad;
            if (sel_hit(lo_reg, `RMP_SEL_DIR_B)) db_next = ad;
        end
        if (pwr_n && !pwr_d_reg) begin
            oa_next = la_reg;
            ob_next = lb_reg;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            da_reg <= `RMP_DIR_RESET;
            db_reg <= `RMP_DIR_RESET;
            la_reg <= `RMP_BYTE_ZERO;
            lb_reg <= `RMP_BYTE_ZERO;
            oa_reg <= `RMP_BYTE_ZERO;
            ob_reg <= `RMP_BYTE_ZERO;
            pwr_d_reg <= 1'b1;
            dout_reg <= `RMP_BYTE_ZERO;
        end else begin
            da_reg <= da_next;
            db_reg <= db_next;
            la_reg <= la_next;
            lb_reg <= lb_next;
            oa_reg <= oa_next;
            ob_reg <= ob_next;
            pwr_d_reg <= pwr_n;
            dout_reg <= dout_next;
        end
    end

    // Wait output: low while selected during latch strobe, freed next edge
    rmp_wait_t wst_reg, wst_next;
    always_comb begin
        wst_next = wst_reg;
        unique case (wst_reg)
            RMP_WAIT_IDLE: if (ale && !ce_n && ce) wst_next = RMP_WAIT_LOW;
            RMP_WAIT_LOW: wst_next = RMP_WAIT_HOLD;
            RMP_WAIT_HOLD: if (!ale) wst_next = RMP_WAIT_IDLE;
            default: wst_next = RMP_WAIT_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) wst_reg <= RMP_WAIT_IDLE;
        else wst_reg <= wst_next;
    end

    // Outputs; pin direction bit by bit from direction registers
    assign muxed_addr_data_o = dout_reg;
    assign muxed_addr_data_oe_o = bus_drive;
    assign wait_o = 1'b0;
    assign wait_oe_o = (wst_reg == RMP_WAIT_LOW);
    assign first_port_pins_o = oa_reg;
    assign first_port_pins_oe_o = da_reg;
    assign second_port_pins_o = ob_reg;
    assign second_port_pins_oe_o = db_reg;

    // Checks
    a_dir_reset: assert property (@(posedge sys_clk_i) rst_i |=> da_reg == 8'h00 && db_reg == 8'h00)
        else $error("direction not cleared");
    a_bus_float: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !sel_ok_reg |-> !muxed_addr_data_oe_o) else $error("bus driven unselected");
    a_bus_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        rd_n && prd_n |-> !muxed_addr_data_oe_o) else $error("bus driven idle");
    a_wait_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wait_oe_o |=> !wait_oe_o) else $error("wait too long");
    a_wait_start: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wst_reg == RMP_WAIT_IDLE && ale && !ce_n && ce |=> wait_oe_o) else $error("no wait");
    a_pin_glitch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !pwr_n |=> $stable(first_port_pins_o)) else $error("pin changed in write");
    a_port_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr && lo_reg[1:0] == 2'h0 |=> la_reg == $past(ad)) else $error("port a write");
    a_dir_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr && lo_reg[1:0] == 2'h3 |=> db_reg == $past(ad)) else $error("dir b write");
endmodule

/* rmp_cpu_model.sv */
// Bus master model issuing latch, read and write cycles
`timescale 1ns/100ps
module rmp_cpu_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] dout_i,
    input wire logic doe_i,
    input wire logic woe_i,
    output logic ale_o = 1'b0,
    output logic cs_n_o = 1'b1,
    output logic cs_o = 1'b0,
    output logic iom_o = 1'b0,
    output logic rd_n_o = 1'b1,
    output logic prd_n_o = 1'b1,
    output logic pwr_n_o = 1'b1,
    output logic [2:0] up_o = 3'h0,
    output logic [7:0] ad_o = 8'h00
);
    // One access; op 0 read, 1 port read, 2 write; wait seen around the latch
    task automatic cyc(input logic [10:0] a, input logic io, input logic on,
        input logic [1:0] op, input logic [7:0] d, output logic [7:0] q,
        output logic oe, output logic wt);
        wt = 1'b0;
        @(posedge sys_clk_i);
        ad_o <= a[7:0];
        up_o <= a[10:8];
        iom_o <= io;
        cs_n_o <= ~on;
        cs_o <= on;
        ale_o <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk_i);
            wt = wt | woe_i;
            if (i == 3) ale_o <= 1'b0;
        end
        // Address hold expired: show the inverse, not a stale value
        ad_o <= ~a[7:0];
        @(posedge sys_clk_i);
        ad_o <= d;
        if (op == 2'h2) pwr_n_o <= 1'b0;
        else if (op == 2'h1) prd_n_o <= 1'b0;
        else rd_n_o <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        q = dout_i;
        oe = doe_i;
        rd_n_o <= 1'b1;
        prd_n_o <= 1'b1;
        pwr_n_o <= 1'b1;
        ad_o <= ~d;
        // Pins settle a few edges after the write strobe rises
        repeat (6) @(posedge sys_clk_i);
        cs_n_o <= 1'b1;
        cs_o <= 1'b0;
    endtask
endmodule

/* tb_rmp_port.sv */
// Self-checking bench for the ROM and dual port bus block
`timescale 1ns/100ps
module tb_rmp_port;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ale, csn, cs, iom, rdn, iorn, iown, doe, wt, woe, oe, w;
    logic [2:0] up;
    logic [7:0] ad, dout, pa_o, pa_oe, pb_o, pb_oe, pa_w, pb_w, q;
    int bad_count = 0;
    int n_tests = 0;
    // Pin level: our driver where enabled, an outside pattern elsewhere
    assign pa_w = (pa_o & pa_oe) | (8'hc3 & ~pa_oe);
    assign pb_w = (pb_o & pb_oe) | (8'h96 & ~pb_oe);
    always #50 sys_clk_i = ~sys_clk_i;
    rmp_cpu_model rmp_cpu_model_inst (.sys_clk_i(sys_clk_i), .dout_i(dout), .doe_i(doe),
        .woe_i(woe), .ale_o(ale), .cs_n_o(csn), .cs_o(cs), .iom_o(iom), .rd_n_o(rdn),
        .prd_n_o(iorn), .pwr_n_o(iown), .up_o(up), .ad_o(ad));
    rmp_port rmp_port_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_latch_i(ale),
        .chip_sel_low_active_i(csn), .chip_sel_high_active_i(cs), .io_mem_sel_i(iom),
        .read_strobe_n_i(rdn), .port_read_strobe_n_i(iorn), .port_write_strobe_n_i(iown),
        .upper_rom_addr_i(up), .muxed_addr_data_i(ad), .muxed_addr_data_o(dout),
        .muxed_addr_data_oe_o(doe), .wait_o(wt), .wait_oe_o(woe),
        .first_port_pins_i(pa_w), .first_port_pins_o(pa_o), .first_port_pins_oe_o(pa_oe),
        .second_port_pins_i(pb_w), .second_port_pins_o(pb_o), .second_port_pins_oe_o(pb_oe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("Checks %0d, errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Reset values of directions and bus drive
    task automatic t_reset();
        chk(pa_oe, 8'h00);
        chk(pb_oe, 8'h00);
        chk({7'h0, doe}, 8'h00);
    endtask
    // ROM reads at the top end of the array and at address 0x123
    task automatic t_rom();
        logic [10:0] a;
        a = 11'h7ff;
        repeat (2) begin
            rmp_cpu_model_inst.cyc(a, 1'b0, 1'b1, 2'h0, 8'h00, q, oe, w);
            chk(q, a[7:0] ^ a[10:3]);
            chk({7'h0, oe}, 8'h01);
            chk({7'h0, w}, 8'h01);
            chk({7'h0, wt}, 8'h00);
            a = 11'h123;
        end
    endtask
    // Direction and port writes, port reads both ways
    task automatic t_ports();
        rmp_cpu_model_inst.cyc(11'h002, 1'b1, 1'b1, 2'h2, 8'h5a, q, oe, w);
        rmp_cpu_model_inst.cyc(11'h000, 1'b0, 1'b1, 2'h2, 8'h3c, q, oe, w);
        chk(pa_oe, 8'h5a);
        chk(pa_o, 8'h3c);
        rmp_cpu_model_inst.cyc(11'h000, 1'b1, 1'b1, 2'h0, 8'h00, q, oe, w);
        chk(q, (8'h3c & 8'h5a) | (8'hc3 & ~8'h5a));
        rmp_cpu_model_inst.cyc(11'h000, 1'b0, 1'b1, 2'h1, 8'h00, q, oe, w);
        chk(q, (8'h3c & 8'h5a) | (8'hc3 & ~8'h5a));
        rmp_cpu_model_inst.cyc(11'h703, 1'b1, 1'b1, 2'h2, 8'hff, q, oe, w);
        rmp_cpu_model_inst.cyc(11'h501, 1'b1, 1'b1, 2'h2, 8'ha5, q, oe, w);
        chk(pb_oe, 8'hff);
        chk(pb_o, 8'ha5);
        rmp_cpu_model_inst.cyc(11'h001, 1'b1, 1'b1, 2'h0, 8'h00, q, oe, w);
        chk(q, 8'ha5);
        rmp_cpu_model_inst.cyc(11'h002, 1'b1, 1'b1, 2'h0, 8'h00, q, oe, w);
        chk(q, 8'h00);
    endtask
    // Deselected write and read must be ignored
    task automatic t_desel();
        rmp_cpu_model_inst.cyc(11'h000, 1'b1, 1'b0, 2'h2, 8'h11, q, oe, w);
        chk(pa_o, 8'h3c);
        chk({7'h0, w}, 8'h00);
        rmp_cpu_model_inst.cyc(11'h000, 1'b1, 1'b0, 2'h0, 8'h00, q, oe, w);
        chk({7'h0, oe}, 8'h00);
    endtask
    // Watchdog sized well above the expected run
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        bad_count++;
        results();
    end
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        t_reset();
        t_rom();
        t_ports();
        t_desel();
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        t_reset();
        results();
    end
endmodule
